// ### common/sft_consts.vh
`ifndef SFT_CONSTS_VH
`define SFT_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define SFT_RXCFG_OFS 8'h00
`define SFT_TXCFG_OFS 8'h04
`define SFT_SETUP_OFS 8'h08
`define SFT_DATA_OFS 8'h0c
`define SFT_LEVEL_OFS 8'h10
`define SFT_IRQ_STAT_OFS 8'h14
`define SFT_IRQ_EN_OFS 8'h18
`define SFT_IRQ_CLR_OFS 8'h1c

// ****************************************
// queue configuration fields
// ****************************************
`define SFT_CFG_FLUSH_BIT 7
`define SFT_CFG_COND_BIT 6
`define SFT_CFG_THR_LSB 0
`define SFT_RXCFG_RST 3'h0
`define SFT_TXCFG_RST 3'h0

// ****************************************
// setup register fields
// ****************************************
`define SFT_SETUP_QEN_BIT 0
`define SFT_SETUP_DPX_LSB 1
`define SFT_SETUP_RXIE_BIT 3
`define SFT_SETUP_TXIE_BIT 4
`define SFT_SETUP_CHEN_BIT 5
`define SFT_SETUP_IDLE_BIT 6
`define SFT_SETUP_W 7
`define SFT_SETUP_RST 7'h00
`define SFT_DPX_HALF_RX 2'h1
`define SFT_DPX_HALF_TX 2'h2
`define SFT_DPX_FULL 2'h3

// ****************************************
// queue capacities and thresholds
// ****************************************
`define SFT_CAP_NONE 3'h0
`define SFT_CAP_HALF 3'h4
`define SFT_CAP_FULL 3'h2
// 3-bit level per threshold code, code 0 in bits 2:0
`define SFT_RX_THR_HALF 12'h68c
`define SFT_RX_THR_FULL 12'h28a
`define SFT_TX_THR_HALF 12'h688
`define SFT_TX_THR_FULL 12'h208

// ****************************************
// interrupt bits
// ****************************************
`define SFT_IRQ_RX_BIT 0
`define SFT_IRQ_TX_BIT 1
`define SFT_IRQ_RST 2'h0

`endif

// ### hdl/sft_byte_mem.v
`timescale 1ns/1ns
// ****************************************
// small byte store with registered read
// ****************************************
module sft_byte_mem #(
    parameter DATA_W = 8,
    parameter ADDR_W = 2
) (
    input wire pclk,
    input wire presetn,
    input wire we,
    input wire [ADDR_W-1:0] waddr,
    input wire [DATA_W-1:0] wdata,
    input wire [ADDR_W-1:0] raddr,
    output wire [DATA_W-1:0] rdata
);

    reg [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];
    reg [DATA_W-1:0] rdata_r;

    always @(posedge pclk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    // bypass so a byte written into an empty queue shows at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= {DATA_W{1'b0}};
        end else if (we && (waddr == raddr)) begin
            rdata_r <= wdata;
        end else begin
            rdata_r <= mem_r[raddr];
        end
    end

    assign rdata = rdata_r;

endmodule // sft_byte_mem

// ### hdl/sft_queue_ctrl.v
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "sft_consts.vh"
// What this block does
// - writing one to rx_queue_flush empties the receive queue and the bit always reads zero.
// - rx condition 0 raises the receive event when the fill reaches the threshold, 1 also when a read leaves it at or above.
// - writing one to tx_queue_flush empties the transmit queue and the bit always reads zero.
// - tx condition 0 raises the transmit event when the fill reaches the threshold, 1 also when a take-out leaves it below.
// - tx threshold codes 00/01/10/11 mean empty/1/2/3 bytes outside full duplex and empty/1/empty/1 in full duplex.
// - enabled queues hold four bytes in their half duplex direction and two bytes each in full duplex.
// - the receive threshold event is passed on only while rx_queue_irq_enable is set.
module sft_queue_ctrl #(
    parameter ADDR_W = 12
) (
    input wire pclk,
    input wire presetn,
    input wire [ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire rx_in_valid,
    input wire [7:0] rx_in_byte,
    output wire rx_in_ready,
    output wire tx_out_valid,
    output wire [7:0] tx_out_byte,
    input wire tx_out_ready,
    input wire lowpower_wake,
    output wire queue_enable,
    output wire [1:0] duplex_sel,
    output wire channel_enable,
    output wire idle_run_allow,
    output wire irq
);

    // ****************************************
    // bus decode
    // ****************************************
    wire setup_ph = psel & ~penable;
    wire access = psel & penable;
    // only aligned words below offset 0x20 are mapped
    wire mapped = (paddr[ADDR_W-1:5] == {(ADDR_W-5){1'b0}}) && (paddr[1:0] == 2'h0);
    wire [7:0] ofs = {3'h0, paddr[4:0]};
    wire wr = access & pwrite & mapped;
    wire wr_rxcfg = wr && (ofs == `SFT_RXCFG_OFS);
    wire wr_txcfg = wr && (ofs == `SFT_TXCFG_OFS);
    wire wr_setup = wr && (ofs == `SFT_SETUP_OFS);
    wire wr_data = wr && (ofs == `SFT_DATA_OFS);
    wire wr_irq_en = wr && (ofs == `SFT_IRQ_EN_OFS);
    wire wr_irq_clr = wr && (ofs == `SFT_IRQ_CLR_OFS);

    // every access completes in its first cycle
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ****************************************
    // configuration registers
    // ****************************************
    reg rx_cs_r;
    reg [1:0] rx_thr_r;
    reg tx_cs_r;
    reg [1:0] tx_thr_r;
    reg [`SFT_SETUP_W-1:0] setup_r;
    reg [1:0] irq_stat_r;
    reg [1:0] irq_en_r;
    reg pop_ok_r;

    // setup register fields drive the rest of the channel
    wire qen = setup_r[`SFT_SETUP_QEN_BIT];
    wire [1:0] dpx = setup_r[`SFT_SETUP_DPX_LSB +: 2];
    wire full_dpx = (dpx == `SFT_DPX_FULL);

    assign queue_enable = qen;
    assign duplex_sel = dpx;
    assign channel_enable = setup_r[`SFT_SETUP_CHEN_BIT];
    assign idle_run_allow = setup_r[`SFT_SETUP_IDLE_BIT];

    // stopping the channel or waking without idle run drops the tx setting
    wire tx_cfg_lost = (wr_setup & ~pwdata[`SFT_SETUP_CHEN_BIT] & setup_r[`SFT_SETUP_CHEN_BIT]) |
                       (lowpower_wake & ~setup_r[`SFT_SETUP_IDLE_BIT]);

    // unused config bits are not stored, so they read zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rx_cs_r, rx_thr_r} <= `SFT_RXCFG_RST;
            {tx_cs_r, tx_thr_r} <= `SFT_TXCFG_RST;
            setup_r <= `SFT_SETUP_RST;
            irq_en_r <= `SFT_IRQ_RST;
        end else begin
            if (wr_rxcfg) begin
                rx_cs_r <= pwdata[`SFT_CFG_COND_BIT];
                rx_thr_r <= pwdata[`SFT_CFG_THR_LSB +: 2];
            end
            if (tx_cfg_lost) begin
                {tx_cs_r, tx_thr_r} <= `SFT_TXCFG_RST;
            end else if (wr_txcfg) begin
                tx_cs_r <= pwdata[`SFT_CFG_COND_BIT];
                tx_thr_r <= pwdata[`SFT_CFG_THR_LSB +: 2];
            end
            if (wr_setup) begin
                setup_r <= pwdata[`SFT_SETUP_W-1:0];
            end
            if (wr_irq_en) begin
                irq_en_r <= pwdata[1:0];
            end
        end
    end

    // ****************************************
    // capacities and thresholds
    // ****************************************
    reg [2:0] cap_rx;
    reg [2:0] cap_tx;

    // capacity follows queue enable and duplex selection
    always @* begin
        cap_rx = `SFT_CAP_NONE;
        cap_tx = `SFT_CAP_NONE;
        if (qen) begin
            case (dpx)
                `SFT_DPX_HALF_RX: begin
                    cap_rx = `SFT_CAP_HALF;
                end
                `SFT_DPX_HALF_TX: begin
                    cap_tx = `SFT_CAP_HALF;
                end
                `SFT_DPX_FULL: begin
                    cap_rx = `SFT_CAP_FULL;
                    cap_tx = `SFT_CAP_FULL;
                end
                default: begin
                    cap_rx = `SFT_CAP_NONE;
                    cap_tx = `SFT_CAP_NONE;
                end
            endcase
        end
    end

    // tables hold a 3-bit level per two-bit code
    wire [11:0] rx_tbl = full_dpx ? `SFT_RX_THR_FULL : `SFT_RX_THR_HALF;
    wire [11:0] tx_tbl = full_dpx ? `SFT_TX_THR_FULL : `SFT_TX_THR_HALF;
    wire [2:0] rx_level_thr = rx_tbl[rx_thr_r*3 +: 3];
    wire [2:0] tx_level_thr = tx_tbl[tx_thr_r*3 +: 3];

    // ****************************************
    // queue pointers and storage
    // ****************************************
    wire [1:0] push_req;
    wire [1:0] pop_req;
    wire [1:0] flush;
    wire [5:0] cap;
    wire [15:0] wdata;
    wire [1:0] push;
    wire [1:0] pop;
    wire [5:0] lvl;
    wire [5:0] lvl_nxt;
    wire [15:0] rdata;

    wire rd_data_acc = access & ~pwrite & mapped & (ofs == `SFT_DATA_OFS);

    assign push_req = {wr_data, rx_in_valid};
    // a data read pops only if a byte stood at its setup cycle
    assign pop_req = {tx_out_ready, rd_data_acc & pop_ok_r};
    wire rx_flush = wr_rxcfg & pwdata[`SFT_CFG_FLUSH_BIT];
    wire tx_flush = wr_txcfg & pwdata[`SFT_CFG_FLUSH_BIT];
    assign flush = {tx_flush, rx_flush};
    assign cap = {cap_tx, cap_rx};
    assign wdata = {pwdata[7:0], rx_in_byte};

    // two-byte queues wrap on bit 0 only
    function [1:0] ptr_step;
        input [1:0] ptr;
        input two;
        begin
            ptr_step = two ? {1'b0, ~ptr[0]} : ptr + 2'h1;
        end
    endfunction

    // one pointer pair and level counter per direction, rx is entry 0
    genvar q;
    generate
        for (q = 0; q < 2; q = q + 1) begin : g_queue
            reg [1:0] wp_r;
            reg [1:0] rp_r;
            reg [2:0] lvl_r;
            wire two = (cap[q*3 +: 3] == `SFT_CAP_FULL);
            wire [1:0] rp_nxt;

            assign push[q] = push_req[q] & (lvl_r < cap[q*3 +: 3]);
            assign pop[q] = pop_req[q] & (lvl_r != 3'h0);
            assign lvl_nxt[q*3 +: 3] = flush[q] ? 3'h0 : lvl_r + {2'h0, push[q]} - {2'h0, pop[q]};
            assign lvl[q*3 +: 3] = lvl_r;
            assign rp_nxt = flush[q] ? 2'h0 : (pop[q] ? ptr_step(rp_r, two) : rp_r);

            // flush wins over a push or pop in the same cycle
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    wp_r <= 2'h0;
                    rp_r <= 2'h0;
                    lvl_r <= 3'h0;
                end else if (flush[q]) begin
                    wp_r <= 2'h0;
                    rp_r <= 2'h0;
                    lvl_r <= 3'h0;
                end else begin
                    if (push[q]) begin
                        wp_r <= ptr_step(wp_r, two);
                    end
                    rp_r <= rp_nxt;
                    lvl_r <= lvl_nxt[q*3 +: 3];
                end
            end

            // reading at the next pointer keeps the head byte in the output flop
            sft_byte_mem #(
                .DATA_W(8),
                .ADDR_W(2)
            ) u_mem (
                .pclk(pclk),
                .presetn(presetn),
                .we(push[q] & ~flush[q]),
                .waddr(wp_r),
                .wdata(wdata[q*8 +: 8]),
                .raddr(rp_nxt),
                .rdata(rdata[q*8 +: 8])
            );
        end
    endgenerate

    assign rx_in_ready = lvl[2:0] < cap_rx;
    assign tx_out_valid = lvl[5:3] != 3'h0;
    assign tx_out_byte = rdata[15:8];

    // ****************************************
    // threshold events and interrupt
    // ****************************************
    // level after this edge, used by the threshold compares
    wire [2:0] rx_after = lvl_nxt[2:0];
    wire [2:0] tx_after = lvl_nxt[5:3];
    // a push and a pop together keep the level, and a flush never raises an event
    wire rx_only_push = push[0] & ~pop[0] & ~flush[0];
    wire rx_only_pop = pop[0] & ~push[0] & ~flush[0];
    wire tx_only_pop = pop[1] & ~push[1] & ~flush[1];

    wire rx_evt = (rx_only_push & (rx_after == rx_level_thr)) |
                  (rx_cs_r & rx_only_pop & (rx_after >= rx_level_thr));
    wire tx_evt = (tx_only_pop & (tx_after == tx_level_thr)) |
                  (tx_cs_r & tx_only_pop & (tx_after < tx_level_thr));

    wire [1:0] irq_set;
    assign irq_set[`SFT_IRQ_RX_BIT] = rx_evt & qen & setup_r[`SFT_SETUP_RXIE_BIT];
    assign irq_set[`SFT_IRQ_TX_BIT] = tx_evt & qen & setup_r[`SFT_SETUP_TXIE_BIT];
    // clear bits come only from a write to the clear register
    wire [1:0] irq_clr = wr_irq_clr ? pwdata[1:0] : 2'h0;

    // a set in the clearing cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= `SFT_IRQ_RST;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // level output, high while an enabled status bit stands
    assign irq = |(irq_stat_r & irq_en_r);

    // ****************************************
    // read data, captured in the setup cycle
    // ****************************************
    reg [31:0] rd_mux;

    always @* begin
        case (ofs)
            `SFT_RXCFG_OFS: rd_mux = {24'h0, 1'b0, rx_cs_r, 4'h0, rx_thr_r};
            `SFT_TXCFG_OFS: rd_mux = {24'h0, 1'b0, tx_cs_r, 4'h0, tx_thr_r};
            `SFT_SETUP_OFS: rd_mux = {25'h0, setup_r};
            `SFT_DATA_OFS: rd_mux = {24'h0, (lvl[2:0] != 3'h0) ? rdata[7:0] : 8'h00};
            `SFT_LEVEL_OFS: rd_mux = {21'h0, lvl[5:3], 5'h0, lvl[2:0]};
            `SFT_IRQ_STAT_OFS: rd_mux = {30'h0, irq_stat_r};
            `SFT_IRQ_EN_OFS: rd_mux = {30'h0, irq_en_r};
            default: rd_mux = 32'h0;
        endcase
    end

    // a data read captures the head byte before its pop in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pop_ok_r <= 1'b0;
        end else if (setup_ph) begin
            prdata <= (mapped && !pwrite) ? rd_mux : 32'h0;
            pop_ok_r <= mapped & ~pwrite & (ofs == `SFT_DATA_OFS) & (lvl[2:0] != 3'h0);
        end else if (access) begin
            pop_ok_r <= 1'b0;
        end
    end

endmodule // sft_queue_ctrl

// ### verif/sft_shift_model.sv
`timescale 1ns/1ns
// ****************************************
// serial shift register side of the queues
// ****************************************
module sft_shift_model (
    input logic pclk,
    input logic hold,
    input logic rx_in_ready,
    output logic rx_in_valid,
    output logic [7:0] rx_in_byte,
    output logic tx_out_ready
);
    int misses = 0;
    initial begin
        rx_in_valid = 1'b0;
        rx_in_byte = 8'h00;
        tx_out_ready = 1'b0;
    end
    // transmit side stalls at random unless held off
    always @(posedge pclk) begin
        tx_out_ready <= !hold && ($urandom_range(1, 0) == 1);
    end
    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        @(posedge pclk);
        rx_in_valid <= 1'b1;
        rx_in_byte <= b;
        do begin
            @(posedge pclk);
            n++;
        end while (rx_in_ready !== 1'b1 && n < 20);
        if (rx_in_ready !== 1'b1) begin
            misses++;
            $display("unexpected at %0t: rx byte never taken", $time);
        end
        rx_in_valid <= 1'b0;
        // released line shows the inverse of the last byte
        rx_in_byte <= ~b;
    endtask
endmodule // sft_shift_model

// ### verif/sft_queue_ctrl_props.sv
`timescale 1ns/1ns
`include "sft_consts.vh"
module sft_queue_ctrl_props #(
    parameter ADDR_W = 12
) (
    input logic pclk,
    input logic presetn,
    input logic [ADDR_W-1:0] paddr,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic rx_in_valid,
    input logic [7:0] rx_in_byte,
    input logic rx_in_ready,
    input logic tx_out_valid,
    input logic [7:0] tx_out_byte,
    input logic tx_out_ready,
    input logic lowpower_wake,
    input logic queue_enable,
    input logic [1:0] duplex_sel,
    input logic channel_enable,
    input logic idle_run_allow,
    input logic irq
);
    // ****************************************
    // receive fill level seen from the ports
    // ****************************************
    logic [2:0] lvl_r;
    logic [2:0] lvl_nxt;
    logic [2:0] cap;
    logic acc;
    logic pop_ok;
    assign acc = psel && penable && pready;
    assign cap = !queue_enable ? `SFT_CAP_NONE : (duplex_sel == `SFT_DPX_HALF_RX) ? `SFT_CAP_HALF :
                 (duplex_sel == `SFT_DPX_FULL) ? `SFT_CAP_FULL : `SFT_CAP_NONE;
    always @* begin
        lvl_nxt = lvl_r + {2'h0, rx_in_valid && rx_in_ready};
        lvl_nxt = lvl_nxt - {2'h0, acc && !pwrite && paddr == ADDR_W'(`SFT_DATA_OFS) && pop_ok};
        if (acc && pwrite && paddr == ADDR_W'(`SFT_RXCFG_OFS) && pwdata[7]) begin
            lvl_nxt = 3'h0;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_r <= 3'h0;
            pop_ok <= 1'b0;
        end else begin
            lvl_r <= lvl_nxt;
            if (psel && !penable) begin
                pop_ok <= !pwrite && paddr == ADDR_W'(`SFT_DATA_OFS) && lvl_r != 3'h0;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    rx_ready_level_a: assert property (rx_in_ready == (lvl_r < cap))
        else $error("rx ready disagrees with fill level");
    rx_off_closed_a: assert property ((!queue_enable || duplex_sel == `SFT_DPX_HALF_TX) |-> !rx_in_ready)
        else $error("rx ready while rx queue has no room");
    rx_cfg_read_a: assert property (acc && !pwrite && paddr == ADDR_W'(`SFT_RXCFG_OFS)
        |-> prdata[31:7] == 25'h0 && prdata[5:2] == 4'h0) else $error("rx config read shows flush or unused bits");
    tx_cfg_read_a: assert property (acc && !pwrite && paddr == ADDR_W'(`SFT_TXCFG_OFS)
        |-> prdata[31:7] == 25'h0 && prdata[5:2] == 4'h0) else $error("tx config read shows flush or unused bits");
    tx_flush_empty_a: assert property (acc && pwrite && paddr == ADDR_W'(`SFT_TXCFG_OFS) && pwdata[7]
        |=> !tx_out_valid) else $error("tx queue not empty after flush");
    bad_addr_err_a: assert property (psel && penable && (paddr >> 5) != 0 |-> pslverr)
        else $error("no error on unmapped address");
    zero_wait_a: assert property (psel && !penable |=> pready) else $error("access phase not ready");
    head_hold_a: assert property (tx_out_valid && !tx_out_ready && !(psel && pwrite)
        |=> tx_out_valid && $stable(tx_out_byte)) else $error("tx head byte changed while stalled");
    irq_mask_a: assert property (acc && pwrite && paddr == ADDR_W'(`SFT_IRQ_EN_OFS) && pwdata[1:0] == 2'h0
        |=> !irq [*2]) else $error("irq high with all sources masked");
endmodule // sft_queue_ctrl_props

// ### verif/sft_queue_ctrl_tb_top.sv
`timescale 1ns/1ns
`include "sft_consts.vh"
module sft_queue_ctrl_tb_top;
    localparam logic [11:0] A_RX = {4'h0, `SFT_RXCFG_OFS};
    localparam logic [11:0] A_TX = {4'h0, `SFT_TXCFG_OFS};
    localparam logic [11:0] A_SU = {4'h0, `SFT_SETUP_OFS};
    localparam logic [11:0] A_DA = {4'h0, `SFT_DATA_OFS};
    localparam logic [11:0] A_LV = {4'h0, `SFT_LEVEL_OFS};
    localparam logic [11:0] A_ST = {4'h0, `SFT_IRQ_STAT_OFS};
    localparam logic [11:0] A_EN = {4'h0, `SFT_IRQ_EN_OFS};
    localparam logic [11:0] A_CL = {4'h0, `SFT_IRQ_CLR_OFS};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic lowpower_wake = 1'b0, hold = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_in_valid, rx_in_ready, tx_out_valid, tx_out_ready;
    logic queue_enable, channel_enable, idle_run_allow, irq;
    logic [7:0] rx_in_byte, tx_out_byte, b0, nb;
    logic [1:0] duplex_sel;
    logic [31:0] rd_q[$];
    logic [7:0] tx_q[$];
    int errors = 0, checks = 0;
    int thr[2][4] = '{'{4, 1, 2, 3}, '{2, 1, 2, 1}};
    always #4 pclk = ~pclk;
    sft_queue_ctrl #(.ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in_valid(rx_in_valid), .rx_in_byte(rx_in_byte), .rx_in_ready(rx_in_ready),
        .tx_out_valid(tx_out_valid), .tx_out_byte(tx_out_byte), .tx_out_ready(tx_out_ready),
        .lowpower_wake(lowpower_wake), .queue_enable(queue_enable), .duplex_sel(duplex_sel),
        .channel_enable(channel_enable), .idle_run_allow(idle_run_allow), .irq(irq));
    sft_shift_model far (.pclk(pclk), .hold(hold), .rx_in_ready(rx_in_ready), .rx_in_valid(rx_in_valid),
        .rx_in_byte(rx_in_byte), .tx_out_ready(tx_out_ready));
    task automatic close_out();
        errors += far.misses;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) rd_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: no ready in access phase", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask
    task automatic drain();
        int n;
        n = 0;
        hold <= 1'b0;
        while (tx_out_valid !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (tx_out_valid !== 1'b0) begin
            errors++;
            $display("unexpected at %0t: tx queue not drained", $time);
        end
        hold <= 1'b1;
    endtask
    task automatic fill_tx(input int k, input int kept);
        for (int i = 0; i < k; i++) begin
            nb = 8'($urandom);
            wr(A_DA, {24'h0, nb});
            if (i < kept) tx_q.push_back(nb);
        end
    endtask
    task automatic wake();
        @(posedge pclk);
        lowpower_wake <= 1'b1;
        @(posedge pclk);
        lowpower_wake <= 1'b0;
    endtask
    // ****************************************
    // result watcher
    // ****************************************
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) chk(prdata, rd_q.size() ? rd_q.pop_front() : 32'hx);
        if (tx_out_valid === 1'b1 && tx_out_ready) chk({24'h0, tx_out_byte}, tx_q.size() ? {24'h0, tx_q.pop_front()} : 32'hx);
    end
    initial begin
        #400000;
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(32'hb43d5a2b));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_RX, 32'h0);
        rd(A_TX, 32'h0);
        wr(A_RX, 32'hffffffff);
        rd(A_RX, 32'h43);
        wr(A_TX, 32'hffffffff);
        rd(A_TX, 32'h43);
        rd(12'h100, 32'h0);
        wr(A_EN, 32'h3);
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                wr(A_SU, m ? 32'h0f : 32'h0b);
                wr(A_RX, 32'h80 | c);
                wr(A_CL, 32'h3);
                for (int i = 0; i < thr[m][c]; i++) begin
                    if (i == thr[m][c] - 1) rd(A_ST, 32'h0);
                    nb = 8'($urandom);
                    if (i == 0) b0 = nb;
                    far.send(nb);
                end
                rd(A_ST, 32'h1);
                @(negedge pclk);
                chk({31'h0, irq}, 32'h1);
                rd(A_DA, {24'h0, b0});
                wr(A_RX, 32'h80);
                rd(A_LV, 32'h0);
            end
        end
        wr(A_SU, 32'h03);
        wr(A_RX, 32'h81);
        wr(A_CL, 32'h3);
        far.send(8'h5a);
        rd(A_ST, 32'h0);
        wr(A_RX, 32'h80);
        wr(A_SU, 32'h0b);
        wr(A_RX, 32'hc1);
        far.send(8'ha5);
        far.send(8'h3c);
        wr(A_CL, 32'h3);
        rd(A_DA, 32'ha5);
        rd(A_ST, 32'h1);
        wr(A_EN, 32'h0);
        wr(A_CL, 32'h3);
        wr(A_EN, 32'h3);
        rd(A_ST, 32'h0);
        wr(A_RX, 32'h80);
        wr(A_SU, 32'h1f);
        wr(A_RX, 32'h80);
        wr(A_TX, 32'h82);
        wr(A_CL, 32'h3);
        for (int i = 0; i < 2; i++) far.send(8'($urandom));
        @(negedge pclk);
        chk({31'h0, rx_in_ready}, 32'h0);
        fill_tx(3, 2);
        rd(A_LV, 32'h202);
        drain();
        rd(A_ST, 32'h3);
        wr(A_RX, 32'h80);
        wr(A_SU, 32'h15);
        wr(A_TX, 32'h83);
        wr(A_CL, 32'h3);
        fill_tx(5, 4);
        rd(A_LV, 32'h400);
        drain();
        rd(A_ST, 32'h2);
        wr(A_TX, 32'hc3);
        fill_tx(2, 2);
        wr(A_CL, 32'h3);
        drain();
        rd(A_ST, 32'h2);
        fill_tx(1, 0);
        wr(A_TX, 32'h80);
        rd(A_LV, 32'h0);
        wr(A_SU, 32'h35);
        wr(A_TX, 32'h43);
        chk({31'h0, channel_enable}, 32'h1);
        wr(A_SU, 32'h15);
        rd(A_TX, 32'h0);
        chk({31'h0, channel_enable}, 32'h0);
        wr(A_SU, 32'h55);
        wr(A_TX, 32'h41);
        wake();
        rd(A_TX, 32'h41);
        chk({31'h0, idle_run_allow}, 32'h1);
        wr(A_SU, 32'h15);
        wake();
        rd(A_TX, 32'h0);
        repeat (4) @(posedge pclk);
        close_out();
    end
endmodule // sft_queue_ctrl_tb_top
bind sft_queue_ctrl sft_queue_ctrl_props #(.ADDR_W(ADDR_W)) props (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_in_valid(rx_in_valid), .rx_in_byte(rx_in_byte),
    .rx_in_ready(rx_in_ready), .tx_out_valid(tx_out_valid), .tx_out_byte(tx_out_byte),
    .tx_out_ready(tx_out_ready), .lowpower_wake(lowpower_wake), .queue_enable(queue_enable),
    .duplex_sel(duplex_sel), .channel_enable(channel_enable), .idle_run_allow(idle_run_allow), .irq(irq));
